// ==== src/rbss_pkg.sv ====
/*
 Package for the reset, supply and boot sequencer: timing constants, strap
 field positions, state and mode types and the packed carriers.
 Assumes a 250 MHz clock that keeps running while the reset pin is low.
*/
`default_nettype none
package rbss_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	// Reset pulse figures in ns
	localparam int DIG_MIN_NS = 100;
	localparam int DIG_MAX_NS = 1000;
	localparam int ANA_MIN_NS = 10000;
	// Startup figures in us
	localparam int PLL_START_US = 3000;
	localparam int STRAP_SENSE_US = 3000;
	localparam int OPERATE_MAX_US = 1000000;
	// Least times round up, longest times round down
	localparam int DIG_MIN_CYC = (DIG_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DIG_MAX_CYC = (DIG_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int ANA_MIN_CYC = (ANA_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint PLL_START_CYC = (longint'(PLL_START_US) * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam longint STRAP_SENSE_CYC = (longint'(STRAP_SENSE_US) * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam longint OPERATE_MAX_CYC = (longint'(OPERATE_MAX_US) * 1000000) / CLK_PERIOD_PS;
	localparam int WIDTH_CNT_W = 16;
	localparam int WAIT_CNT_W = 32;
	// Strap field positions
	localparam int STRAP_W = 3;
	localparam int STRAP_CLK_LSB = 0;
	localparam int STRAP_BOOT_BIT = 2;
	localparam int HOST_CLK_EDGES = 2;
	localparam logic [2:0] STRAP_RESET_VAL = 3'h0;

	typedef enum logic [1:0] {
		RBSS_CLK_XTAL,
		RBSS_CLK_FS_LOW,
		RBSS_CLK_FS_HIGH,
		RBSS_CLK_RESERVED
	} rbss_clk_src_t;

	typedef enum {
		RBSS_ST_RESET,
		RBSS_ST_SENSE,
		RBSS_ST_PLL_WAIT,
		RBSS_ST_FLASH_LOAD,
		RBSS_ST_HOST_WAIT,
		RBSS_ST_RUN
	} rbss_state_t;

	typedef enum logic [1:0] {
		RBSS_RST_NONE,
		RBSS_RST_DIGITAL,
		RBSS_RST_ANALOG
	} rbss_rst_kind_t;

	typedef struct packed {
		rbss_clk_src_t clk_src;
		logic auto_boot;
		logic [2:0] raw;
	} rbss_boot_sense_t;

	typedef struct packed {
		logic host_spi_mode;
		logic host_interrupt_n;
		logic flash_chip_select_mode;
		logic straps_released;
	} rbss_boot_out_t;
endpackage
`default_nettype wire

// ==== src/rbss_sync3.sv ====
/*
 Three-stage synchroniser with agreement filter: output changes once the
 second and third stages agree. Assumes asynchronous inputs.
*/
`default_nettype none
module rbss_sync3
	import rbss_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} rbss_sync_st_t;

	rbss_sync_st_t st_ff;
	rbss_sync_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.q[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_ff <= {INIT, INIT, INIT, INIT};
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.q;
endmodule
`default_nettype wire

// ==== src/rbss_width_meter.sv ====
/*
 Measures the low width of the synchronised reset pin and classifies the
 pulse at its rising edge. Assumes the clock runs throughout the pulse.
*/
`default_nettype none
module rbss_width_meter
	import rbss_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic pin_high,
	output rbss_rst_kind_t kind,
	output logic analog_now,
	output logic in_reset
);
	typedef struct packed {
		logic [WIDTH_CNT_W-1:0] cnt;
		logic prev;
		rbss_rst_kind_t kind;
		logic analog;
	} rbss_meter_st_t;

	rbss_meter_st_t st_ff;
	rbss_meter_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = pin_high;
		nxt_st.kind = RBSS_RST_NONE;
		if (!pin_high) begin
			// Saturating width count on the running clock
			if (st_ff.cnt != '1) begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
			if (st_ff.cnt >= WIDTH_CNT_W'(ANA_MIN_CYC)) begin
				nxt_st.analog = 1'b1;
			end
		end else begin
			nxt_st.cnt = '0;
			if (!st_ff.prev) begin
				if (st_ff.analog) begin
					nxt_st.kind = RBSS_RST_ANALOG;
				end else if (st_ff.cnt >= WIDTH_CNT_W'(DIG_MIN_CYC)) begin
					nxt_st.kind = RBSS_RST_DIGITAL;
				end
			end
			nxt_st.analog = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_ff <= '{cnt: '0, prev: 1'b1, kind: RBSS_RST_NONE, analog: 1'b0};
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign kind = st_ff.kind;
	assign analog_now = st_ff.analog;
	assign in_reset = !st_ff.prev;

	AST_ANALOG_NEEDS_WIDTH: assert property (@(posedge clock) disable iff (srst)
		$rose(st_ff.analog) |-> $past(st_ff.cnt) >= WIDTH_CNT_W'(ANA_MIN_CYC))
		else $error("analog flag set before threshold");
	AST_SHORT_PULSE_IGNORED: assert property (@(posedge clock) disable iff (srst)
		(ce && pin_high && !st_ff.prev && !st_ff.analog
			&& st_ff.cnt < WIDTH_CNT_W'(DIG_MIN_CYC)) |=> st_ff.kind == RBSS_RST_NONE)
		else $error("glitch taken as reset");
endmodule
`default_nettype wire

// ==== src/rbss_top.sv ====
/*
 Reset classification, core supply control and boot sequencing.
 Assumes straps and the reset pin are asynchronous, clock runs always.
*/
// Operation
// - Low pulse of 100 ns to 1 us gives a digital reset of all state.
// - Low pulse over 10 us also resets analog: core supply and PLL off.
// - After analog reset, release re-enables supply and PLL, then waits 3 ms.
// - Any reset release runs boot; analog case waits for clocks first.
// - Straps are sampled on every reset, digital or analog.
// - At power-up wait 3 ms strap sensing, operational within 1 s from flash.
// - Strap high means external supply; control output high enables it.
// - Reset over analog threshold forces core supply control low.
// - Strap low enables internal regulator; control output drives pass FET.
// - Boot runs on reset, power-up and swap; stores straps first. Swap keeps the stored straps and goes straight to host wait.
// - Auto boot copies flash to program RAM, sets defaults, then runs.
// - Host boot and swap wait while host loads program RAM.
// - Straps 1:0 pick crystal, low-rate sync, high-rate sync, reserved.
// - Strap 2 picks host boot at zero, flash auto boot at one.
// - Straps read zero unless pulled up, by internal pull-downs.
// - Auto boot makes GPIO nine the flash chip select.
// - After strap sensing, strapped pins are freed for other use.
// - After PLL lock, post event and pull host interrupt low.
// - Host boot picks SPI slave after two serial clock cycles, else I2C.
// - Right after reset hold GPIOs as inputs, capture their levels.
`default_nettype none
module rbss_top
	import rbss_pkg::*;
#(
	parameter longint PLL_START_CYCLES = PLL_START_CYC,
	parameter longint SENSE_CYCLES = STRAP_SENSE_CYC,
	parameter longint OPERATE_CYCLES = OPERATE_MAX_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic reset_pin_n,
	input wire logic [STRAP_W-1:0] strap_pins,
	input wire logic supply_source_strap,
	input wire logic host_serial_clock,
	input wire logic flash_load_done,
	input wire logic host_load_done,
	input wire logic firmware_swap,
	input wire logic pll_locked,
	output logic core_supply_control,
	output logic internal_regulator_en,
	output logic pll_enable,
	output logic digital_reset,
	output logic gpio_force_input,
	output logic straps_released,
	output logic flash_chip_select_mode,
	output logic flash_load_start,
	output logic config_defaults_load,
	output logic jump_to_ram,
	output logic host_wait,
	output logic host_interrupt_n,
	output logic boot_event,
	output logic host_spi_mode,
	output logic boot_timeout,
	output logic [STRAP_W-1:0] boot_sense_raw,
	output rbss_clk_src_t clock_source,
	output logic auto_boot
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic reset_pin_s;
	logic [STRAP_W-1:0] strap_s;
	logic supply_strap_s;
	logic hclk_s;
	rbss_rst_kind_t rst_kind;
	logic analog_now;
	logic in_reset;

	rbss_sync3 #(.WIDTH(STRAP_W + 3), .INIT({1'b1, STRAP_RESET_VAL, 2'h0})) u_sync (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.din({reset_pin_n, strap_pins, supply_source_strap, host_serial_clock}),
		.dout({reset_pin_s, strap_s, supply_strap_s, hclk_s})
	);

	rbss_width_meter u_meter (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.pin_high(reset_pin_s),
		.kind(rst_kind),
		.analog_now(analog_now),
		.in_reset(in_reset)
	);

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		rbss_state_t state;
		logic analog_pending;
		logic [WAIT_CNT_W-1:0] wait_cnt;
		logic [WAIT_CNT_W-1:0] boot_cnt;
		rbss_boot_sense_t sense;
		logic ext_supply;
		logic supply_on;
		logic pll_on;
		logic dig_rst;
		logic gpio_in;
		logic event_p;
		logic start_p;
		logic defaults_p;
		logic jump_p;
		logic timeout;
		logic hclk_prev;
		logic [1:0] hclk_edges;
		logic wait_out;
		logic reg_en;
		rbss_boot_out_t out;
	} rbss_top_st_t;

	rbss_top_st_t st_ff;
	rbss_top_st_t nxt_st;

	localparam logic [WAIT_CNT_W-1:0] PLL_WAIT = WAIT_CNT_W'(PLL_START_CYCLES);
	localparam logic [WAIT_CNT_W-1:0] SENSE_WAIT = WAIT_CNT_W'(SENSE_CYCLES);
	localparam logic [WAIT_CNT_W-1:0] OP_WAIT = WAIT_CNT_W'(OPERATE_CYCLES);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.event_p = 1'b0;
		nxt_st.start_p = 1'b0;
		nxt_st.defaults_p = 1'b0;
		nxt_st.jump_p = 1'b0;
		nxt_st.dig_rst = 1'b0;
		nxt_st.hclk_prev = hclk_s;
		if (st_ff.state != RBSS_ST_RUN && st_ff.boot_cnt != '1) begin
			nxt_st.boot_cnt = st_ff.boot_cnt + 1'b1;
		end
		if (st_ff.sense.auto_boot && st_ff.boot_cnt >= OP_WAIT
			&& st_ff.state != RBSS_ST_RUN) begin
			nxt_st.timeout = 1'b1;
		end
		// Supply mode follows the strap
		nxt_st.ext_supply = supply_strap_s;

		unique case (st_ff.state)
		RBSS_ST_RESET: begin
			nxt_st.gpio_in = 1'b1;
			nxt_st.dig_rst = 1'b1;
			if (!in_reset) begin
				nxt_st.supply_on = 1'b1;
				nxt_st.pll_on = 1'b1;
				nxt_st.wait_cnt = '0;
				nxt_st.boot_cnt = '0;
				nxt_st.state = RBSS_ST_SENSE;
			end
		end
		RBSS_ST_SENSE: begin
			nxt_st.gpio_in = 1'b1;
			nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
			if (st_ff.wait_cnt >= SENSE_WAIT - 1'b1) begin
				// Straps stored before boot decisions
				nxt_st.sense.raw = strap_s;
				nxt_st.sense.clk_src = rbss_clk_src_t'(strap_s[STRAP_CLK_LSB +: 2]);
				nxt_st.sense.auto_boot = strap_s[STRAP_BOOT_BIT];
				nxt_st.gpio_in = 1'b0;
				nxt_st.out.straps_released = 1'b1;
				nxt_st.wait_cnt = '0;
				nxt_st.state = RBSS_ST_PLL_WAIT;
			end
		end
		RBSS_ST_PLL_WAIT: begin
			if (st_ff.wait_cnt != '1) begin
				nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
			end
			// Analog case also waits the PLL startup time
			if (pll_locked && (!st_ff.analog_pending || st_ff.wait_cnt >= PLL_WAIT)) begin
				nxt_st.analog_pending = 1'b0;
				nxt_st.event_p = 1'b1;
				nxt_st.out.host_interrupt_n = 1'b0;
				if (st_ff.sense.auto_boot) begin
					nxt_st.out.flash_chip_select_mode = 1'b1;
					nxt_st.start_p = 1'b1;
					nxt_st.state = RBSS_ST_FLASH_LOAD;
				end else begin
					nxt_st.hclk_edges = '0;
					nxt_st.state = RBSS_ST_HOST_WAIT;
				end
			end
		end
		RBSS_ST_FLASH_LOAD: begin
			if (flash_load_done) begin
				nxt_st.defaults_p = 1'b1;
				nxt_st.jump_p = 1'b1;
				nxt_st.state = RBSS_ST_RUN;
			end
		end
		RBSS_ST_HOST_WAIT: begin
			if (hclk_s && !st_ff.hclk_prev && st_ff.hclk_edges != 2'(HOST_CLK_EDGES)) begin
				nxt_st.hclk_edges = st_ff.hclk_edges + 1'b1;
			end
			if (st_ff.hclk_edges == 2'(HOST_CLK_EDGES)) begin
				nxt_st.out.host_spi_mode = 1'b1;
			end
			if (host_load_done) begin
				nxt_st.out.host_interrupt_n = 1'b1;
				nxt_st.jump_p = 1'b1;
				nxt_st.state = RBSS_ST_RUN;
			end
		end
		RBSS_ST_RUN: begin
			if (firmware_swap) begin
				// Swap restarts the boot watchdog
				nxt_st.boot_cnt = '0;
				nxt_st.out.host_spi_mode = 1'b0;
				nxt_st.hclk_edges = '0;
				nxt_st.state = RBSS_ST_HOST_WAIT;
			end
		end
		endcase

		// Reset pin overrides everything
		if (in_reset) begin
			nxt_st.state = RBSS_ST_RESET;
			nxt_st.dig_rst = 1'b1;
			nxt_st.gpio_in = 1'b1;
			nxt_st.out = '{host_spi_mode: 1'b0, host_interrupt_n: 1'b1,
				flash_chip_select_mode: 1'b0, straps_released: 1'b0};
			nxt_st.timeout = 1'b0;
			// No boot action may leak out while the pin holds reset
			nxt_st.event_p = 1'b0;
			nxt_st.start_p = 1'b0;
			nxt_st.defaults_p = 1'b0;
			nxt_st.jump_p = 1'b0;
			if (analog_now) begin
				nxt_st.supply_on = 1'b0;
				nxt_st.pll_on = 1'b0;
				nxt_st.analog_pending = 1'b1;
			end
		end

		// Level outputs taken from the next state so each pin is a flop
		nxt_st.wait_out = (nxt_st.state == RBSS_ST_HOST_WAIT);
		nxt_st.reg_en = nxt_st.supply_on & ~nxt_st.ext_supply;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_ff <= '{state: RBSS_ST_SENSE, analog_pending: 1'b1, wait_cnt: '0, boot_cnt: '0,
				sense: '{clk_src: RBSS_CLK_XTAL, auto_boot: 1'b0, raw: STRAP_RESET_VAL},
				ext_supply: 1'b0, supply_on: 1'b1, pll_on: 1'b1, dig_rst: 1'b1,
				gpio_in: 1'b1, event_p: 1'b0, start_p: 1'b0, defaults_p: 1'b0,
				jump_p: 1'b0, timeout: 1'b0, hclk_prev: 1'b0, hclk_edges: '0,
				wait_out: 1'b0, reg_en: 1'b1,
				out: '{host_spi_mode: 1'b0, host_interrupt_n: 1'b1,
				flash_chip_select_mode: 1'b0, straps_released: 1'b0}};
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign core_supply_control = st_ff.supply_on;
	assign internal_regulator_en = st_ff.reg_en;
	assign pll_enable = st_ff.pll_on;
	assign digital_reset = st_ff.dig_rst;
	assign gpio_force_input = st_ff.gpio_in;
	assign straps_released = st_ff.out.straps_released;
	assign flash_chip_select_mode = st_ff.out.flash_chip_select_mode;
	assign flash_load_start = st_ff.start_p;
	assign config_defaults_load = st_ff.defaults_p;
	assign jump_to_ram = st_ff.jump_p;
	assign host_wait = st_ff.wait_out;
	assign host_interrupt_n = st_ff.out.host_interrupt_n;
	assign boot_event = st_ff.event_p;
	assign host_spi_mode = st_ff.out.host_spi_mode;
	assign boot_timeout = st_ff.timeout;
	assign boot_sense_raw = st_ff.sense.raw;
	assign clock_source = st_ff.sense.clk_src;
	assign auto_boot = st_ff.sense.auto_boot;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_ANALOG_SUPPLY_OFF: assert property (@(posedge clock) disable iff (srst)
		(ce && in_reset && analog_now) |=> !core_supply_control && !pll_enable)
		else $error("supply not cut on analog reset");
	AST_RESET_HOLDS_DIGITAL: assert property (@(posedge clock) disable iff (srst)
		(ce && in_reset) |=> digital_reset && gpio_force_input && host_interrupt_n)
		else $error("digital reset not asserted");
	AST_RELEASE_SUPPLY_ON: assert property (@(posedge clock) disable iff (srst)
		(ce && st_ff.state == RBSS_ST_RESET && !in_reset) |=> core_supply_control && pll_enable)
		else $error("supply not restored on release");
	AST_STRAP_DECODE: assert property (@(posedge clock) disable iff (srst)
		$rose(straps_released) |-> clock_source == rbss_clk_src_t'(boot_sense_raw[1:0])
			&& auto_boot == boot_sense_raw[STRAP_BOOT_BIT])
		else $error("strap decode mismatch");
	AST_INT_AFTER_LOCK: assert property (@(posedge clock) disable iff (srst)
		$fell(host_interrupt_n) |-> boot_event && $past(pll_locked))
		else $error("interrupt without lock");
	AST_CS_ONLY_AUTO: assert property (@(posedge clock) disable iff (srst)
		flash_chip_select_mode |-> auto_boot)
		else $error("chip select in host boot");
	AST_FLASH_DONE_JUMP: assert property (@(posedge clock) disable iff (srst)
		(ce && !in_reset && st_ff.state == RBSS_ST_FLASH_LOAD && flash_load_done)
			|=> jump_to_ram && config_defaults_load)
		else $error("no jump after flash load");
	AST_HOST_WAIT_HELD: assert property (@(posedge clock) disable iff (srst)
		(host_wait && !host_load_done && !in_reset) |=> host_wait || !ce)
		else $error("host wait left early");
	AST_REG_MODE: assert property (@(posedge clock) disable iff (srst)
		internal_regulator_en |-> core_supply_control && !st_ff.ext_supply)
		else $error("regulator mode wrong");

	// Sequencing checks
	AST_SENSE_RELEASES_GPIO: assert property (@(posedge clock) disable iff (srst)
		$rose(straps_released) |-> !gpio_force_input)
		else $error("strap pins not released after sensing");
	AST_SPI_NEEDS_WAIT: assert property (@(posedge clock) disable iff (srst)
		$rose(host_spi_mode) |-> $past(host_wait))
		else $error("serial mode picked outside host wait");
	AST_TIMEOUT_AUTO_ONLY: assert property (@(posedge clock) disable iff (srst)
		$rose(boot_timeout) |-> $past(auto_boot))
		else $error("timeout raised in host boot");
	AST_START_WITH_CS: assert property (@(posedge clock) disable iff (srst)
		flash_load_start |-> flash_chip_select_mode && auto_boot)
		else $error("flash load without chip select");
	AST_EVENT_PULSE: assert property (@(posedge clock) disable iff (srst)
		(ce && boot_event) |=> !boot_event)
		else $error("boot event longer than one cycle");
	AST_JUMP_PULSE: assert property (@(posedge clock) disable iff (srst)
		(ce && jump_to_ram) |=> !jump_to_ram)
		else $error("jump longer than one cycle");
	AST_SWAP_TO_HOST: assert property (@(posedge clock) disable iff (srst)
		(ce && !in_reset && st_ff.state == RBSS_ST_RUN && firmware_swap) |=> host_wait)
		else $error("swap did not enter host wait");
	AST_RESET_NO_JUMP: assert property (@(posedge clock) disable iff (srst)
		(ce && in_reset) |=> !jump_to_ram && !flash_load_start)
		else $error("boot action during reset");
endmodule
`default_nettype wire

// ==== tb/rbss_host_model.sv ====
/*
 Far-side model: serial flash answering a load request, or a host that loads
 program RAM, optionally toggling the serial clock first to pick SPI.
 Assumes the sequencer's clock and sync reset; delay sets answer latency.
*/
`default_nettype none
module rbss_host_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic flash_load_start,
	input wire logic flash_chip_select_mode,
	input wire logic host_wait,
	input wire logic use_spi,
	input wire logic [15:0] delay,
	output logic flash_load_done,
	output logic host_load_done,
	output logic host_serial_clock
);
	logic [15:0] cnt;
	logic busy, host, hw_q;
	logic [3:0] tog;
	initial begin
		{flash_load_done, host_load_done, host_serial_clock, busy, host, hw_q} = 6'h0;
		{cnt, tog} = 20'h0;
	end
	// Clock idles low outside the load window
	always @(posedge clock) begin
		flash_load_done <= 1'b0;
		host_load_done <= 1'b0;
		hw_q <= host_wait;
		if (srst) begin
			busy <= 1'b0;
			tog <= 4'h0;
			host_serial_clock <= 1'b0;
		end else if (!busy) begin
			if (flash_load_start && flash_chip_select_mode) begin
				busy <= 1'b1;
				host <= 1'b0;
				cnt <= delay;
			end else if (host_wait && !hw_q) begin
				busy <= 1'b1;
				host <= 1'b1;
				cnt <= delay;
				tog <= use_spi ? 4'hf : 4'h0;
			end
		end else if (tog != 4'h0) begin
			tog <= tog - 4'h1;
			if (tog[1:0] == 2'h1) host_serial_clock <= ~host_serial_clock;
		end else if (cnt != 16'h0) begin
			cnt <= cnt - 16'h1;
		end else begin
			busy <= 1'b0;
			flash_load_done <= !host;
			host_load_done <= host;
		end
	end
endmodule
`default_nettype wire

// ==== tb/rbss_top_tb.sv ====
/*
 Self-checking bench for the reset, supply and boot sequencer.
 Assumes shortened PLL, sense and operate counts set at the instance.
*/
`default_nettype none
module rbss_top_tb import rbss_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, srst, ce, reset_pin_n, supply_source_strap, host_serial_clock;
	logic [STRAP_W-1:0] strap_pins, boot_sense_raw;
	logic flash_load_done, host_load_done, firmware_swap, pll_locked, use_spi;
	logic core_supply_control, internal_regulator_en, pll_enable, digital_reset;
	logic gpio_force_input, straps_released, flash_chip_select_mode, flash_load_start;
	logic config_defaults_load, jump_to_ram, host_wait, host_interrupt_n, boot_event;
	logic host_spi_mode, boot_timeout, auto_boot;
	rbss_clk_src_t clock_source;
	logic [15:0] delay;
	logic ev, fls, cfg, jmp, sup_lo, pll_lo;
	int failures = 0, n_checks = 0, t_int = 0, cyc = 0;

	rbss_top #(.PLL_START_CYCLES(50), .SENSE_CYCLES(20), .OPERATE_CYCLES(2000)) i_rbss_top (
		.clock, .srst, .ce, .reset_pin_n, .strap_pins, .supply_source_strap,
		.host_serial_clock, .flash_load_done, .host_load_done, .firmware_swap, .pll_locked,
		.core_supply_control, .internal_regulator_en, .pll_enable, .digital_reset,
		.gpio_force_input, .straps_released, .flash_chip_select_mode, .flash_load_start,
		.config_defaults_load, .jump_to_ram, .host_wait, .host_interrupt_n, .boot_event,
		.host_spi_mode, .boot_timeout, .boot_sense_raw, .clock_source, .auto_boot);

	rbss_host_model i_rbss_host_model (.clock, .srst, .flash_load_start,
		.flash_chip_select_mode, .host_wait, .use_spi, .delay, .flash_load_done,
		.host_load_done, .host_serial_clock);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Lock follows the enable a cycle later; clocks stay stable through a digital reset, not an analog one
	initial pll_locked = 1'b0;
	always @(posedge clock) pll_locked <= pll_enable;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic pin(input int n);
		sup_lo = 1'b0;
		pll_lo = 1'b0;
		@(posedge clock);
		reset_pin_n <= 1'b0;
		repeat (n) begin
			@(posedge clock);
			sup_lo |= !core_supply_control;
			pll_lo |= !pll_enable;
		end
		chk(3'(digital_reset), 3'h1);
		reset_pin_n <= 1'b1;
	endtask

	task automatic run_boot(input int lim);
		ev = 1'b0;
		fls = 1'b0;
		cfg = 1'b0;
		jmp = 1'b0;
		t_int = -1;
		for (int k = 1; k <= lim && !jmp; k++) begin
			@(posedge clock);
			ev |= boot_event;
			fls |= flash_load_start;
			cfg |= config_defaults_load;
			jmp = jump_to_ram;
			if (t_int < 0 && host_interrupt_n === 1'b0) t_int = k;
		end
		chk(3'(jmp), 3'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_powerup();
		@(posedge clock);
		chk({digital_reset, gpio_force_input, host_interrupt_n}, 3'h7);
		srst <= 1'b0;
		run_boot(400);
		chk({ev, fls, cfg}, 3'h7);
		chk(3'(t_int >= 70), 3'h1);
		chk({auto_boot, flash_chip_select_mode, straps_released}, 3'h7);
		chk(boot_sense_raw, 3'h4);
		chk({core_supply_control, internal_regulator_en, boot_timeout}, 3'h4);
	endtask

	task automatic t_clk_src();
		for (int c = 0; c < 4; c++) begin
			strap_pins <= {1'b0, 2'(c)};
			use_spi <= c[0];
			pin(100);
			run_boot(400);
			chk(3'(clock_source), 3'(c));
			chk({auto_boot, host_spi_mode, host_interrupt_n}, {2'(c[0]), 1'b1});
			chk({ev, 2'(t_int > 0 && t_int < 60)}, 3'h5);
		end
	endtask

	task automatic t_mid_pulse();
		pin(1000);
		chk({sup_lo, pll_lo}, 3'h0);
		run_boot(400);
		chk(3'(t_int > 0 && t_int < 60), 3'h1);
	endtask

	task automatic t_analog();
		supply_source_strap <= 1'b0;
		strap_pins <= 3'h5;
		delay <= 16'h20;
		pin(3000);
		chk({sup_lo, pll_lo}, 3'h3);
		repeat (8) @(posedge clock);
		chk({core_supply_control, pll_enable}, 3'h3);
		run_boot(600);
		chk(3'(t_int >= 62), 3'h1);
		chk({auto_boot, 2'(clock_source)}, 3'h5);
		chk({fls, internal_regulator_en, core_supply_control}, 3'h7);
	endtask

	task automatic t_swap();
		logic hw;
		hw = 1'b0;
		@(posedge clock);
		firmware_swap <= 1'b1;
		@(posedge clock);
		firmware_swap <= 1'b0;
		repeat (4) begin
			@(posedge clock);
			hw |= host_wait;
		end
		chk(3'(hw), 3'h1);
		run_boot(400);
	endtask

	task automatic t_timeout();
		int k;
		supply_source_strap <= 1'b1;
		strap_pins <= 3'h4;
		delay <= 16'd3000;
		pin(100);
		for (k = 0; k < 2600 && boot_timeout !== 1'b1; k++) @(posedge clock);
		chk({boot_timeout, jump_to_ram, core_supply_control}, 3'h5);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		reset_pin_n = 1'b1;
		strap_pins = 3'h4;
		supply_source_strap = 1'b1;
		firmware_swap = 1'b0;
		use_spi = 1'b0;
		delay = 16'ha;
		@(posedge clock);
		t_powerup();
		t_clk_src();
		t_mid_pulse();
		t_analog();
		t_swap();
		t_timeout();
		final_report();
	end
endmodule
`default_nettype wire
